// ==== verilog/fpf_pkg.sv ====
package fpf_pkg;

  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int unsigned NTERM   = 8;     // Comparison terms
  localparam int unsigned NPAT    = 4;     // Filter patterns
  localparam int unsigned NCLS    = 4;     // Clauses per pattern
  localparam int unsigned TIDX_W  = 3;     // Term index width
  localparam int unsigned PAT_W   = 2;     // Pattern index width
  localparam int unsigned CLS_W   = 2;     // Clause index width
  localparam int unsigned CNT_W   = 12;    // Byte counter width
  localparam int unsigned ADDR_W  = 11;    // Frame buffer address
  localparam int unsigned BUF_LEN = 2048;  // Frame buffer bytes
  localparam int unsigned VAL_W   = 32;    // Term value width
  localparam int unsigned NB_W    = 3;     // Term length field
  localparam int unsigned MAX_NB  = 4;     // Longest term, bytes
  localparam int unsigned FIFO_W  = 9;     // Byte plus last flag
  localparam int unsigned FIFO_D  = 16;    // Output FIFO words

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [CNT_W-1:0] CNT_RST = 12'h000;
  localparam logic [7:0]       BYTE_RST = 8'h00;

  // ------------------------------------------------------------
  // Frame sequencer states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    FPF_S_RX   = 3'b001,   // Collect a frame
    FPF_S_EVAL = 3'b010,   // Decide pass or drop
    FPF_S_TX   = 3'b100    // Replay kept frame
  } fpf_state_t;

endpackage

// ==== verilog/fpf_fifo.sv ====
`timescale 1ns/1ns
module fpf_fifo #(
  parameter int unsigned W     = 9,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // Drain side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];   // Storage
  logic [AW-1:0] wr_q;          // Write pointer
  logic [AW-1:0] rd_q;          // Read pointer
  logic [AW:0]   cnt_q;         // Fill level
  logic          push;          // Word taken in
  logic          pop;           // Word handed out

  // ------------------------------------------------------------
  // Handshakes
  // ------------------------------------------------------------
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH)); // Full at DEPTH words
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage write, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // Pointers and level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule

// ==== verilog/fpf_term.sv ====
`timescale 1ns/1ns
module fpf_term
  import fpf_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Received byte stream
  input  wire logic              byte_valid,
  input  wire logic              first,
  input  wire logic [CNT_W-1:0]  byte_cnt,
  input  wire logic [7:0]        byte_data,
  // Term setup
  input  wire logic [CNT_W-1:0]  offset,
  input  wire logic [NB_W-1:0]   nbytes,
  input  wire logic [VAL_W-1:0]  value,
  input  wire logic [VAL_W-1:0]  mask,
  // Result for the current frame
  output logic                   match
);

  logic [CNT_W-1:0] k;       // Byte index inside term
  logic [NB_W-1:0]  sh;      // Byte lane from the right
  logic [7:0]       vb;      // Expected byte
  logic [7:0]       mb;      // Bits that count
  logic             in_rng;  // Byte falls in the term
  logic             hit;     // Byte agrees
  logic             ok_q;    // All bytes so far agree
  logic [NB_W-1:0]  got_q;   // Bytes compared so far

  // Lane select: first byte carries the top digits
  always_comb begin
    k      = byte_cnt - offset;
    in_rng = byte_valid && (byte_cnt >= offset)
             && (k < CNT_W'(nbytes));
    sh     = nbytes - 1'b1 - k[NB_W-1:0];
    vb     = 8'(value >> {sh, 3'b000});
    mb     = 8'(mask >> {sh, 3'b000});
    hit    = ((byte_data ^ vb) & mb) == 8'h00;
  end

  // Accumulate per frame; first byte restarts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ok_q  <= 1'b1;
      got_q <= '0;
    end else if (byte_valid && first) begin
      ok_q  <= !in_rng || hit;
      got_q <= NB_W'(in_rng);
    end else if (in_rng) begin
      ok_q  <= ok_q && hit;
      got_q <= got_q + 1'b1;
    end
  end

  // Short frame never completes the term
  assign match = ok_q && (got_q == nbytes) && (nbytes != '0);

endmodule

// ==== verilog/fpf_filter.sv ====
// Operation
// - Term: byte offset plus hex value
// - Offset 12 two-byte type field compare
// - Drop frame when an assigned pattern holds
// - Negation inverts enclosed comparison
// - Negation applies to whole group
// - Conjunction needs both sides true
// - Negated term allowed inside conjunction
// - Single-byte term compares one octet
// - X digit is a nibble don't-care
// - Quoted nibble gives per-bit care
// - Multicast test on destination top bit
// - All-ones destination term blocks broadcast
// - OR joins alternatives
// - Connect-qualified pattern only while link down
`timescale 1ns/1ns
module fpf_filter
  import fpf_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // Receive stream from the LAN port
  input  wire logic                   rx_valid,
  input  wire logic [7:0]             rx_data,
  input  wire logic                   rx_last,
  output logic                        rx_ready_q,
  // Forward stream to bridge logic
  output logic                        fwd_valid_q,
  output logic [7:0]                  fwd_data_q,
  output logic                        fwd_last_q,
  input  wire logic                   fwd_ready,
  // Term load port
  input  wire logic                   cfg_wr,
  input  wire logic [fpf_pkg::TIDX_W-1:0] cfg_term,
  input  wire logic                   cfg_en,
  input  wire logic [fpf_pkg::CNT_W-1:0]  cfg_offset,
  input  wire logic [fpf_pkg::NB_W-1:0]   cfg_nbytes,
  input  wire logic [fpf_pkg::VAL_W-1:0]  cfg_value,
  input  wire logic [fpf_pkg::VAL_W-1:0]  cfg_mask,
  input  wire logic                   cfg_neg,
  input  wire logic [fpf_pkg::PAT_W-1:0]  cfg_pat,
  input  wire logic [fpf_pkg::CLS_W-1:0]  cfg_cls,
  // Pattern controls
  input  wire logic [fpf_pkg::NPAT-1:0]   pat_en,
  input  wire logic [fpf_pkg::NPAT-1:0]   pat_neg,
  input  wire logic [fpf_pkg::NPAT-1:0]   pat_conn,
  // Remote site link state, asynchronous
  input  wire logic                   link_down,
  // Per-frame verdict pulses
  output logic                        drop_q,
  output logic                        pass_q
);

  import fpf_pkg::*;

  // ------------------------------------------------------------
  // Term table
  // ------------------------------------------------------------
  logic             t_en_q   [NTERM];  // Term in use
  logic [CNT_W-1:0] t_off_q  [NTERM];  // Byte offset
  logic [NB_W-1:0]  t_nb_q   [NTERM];  // Length in bytes
  logic [VAL_W-1:0] t_val_q  [NTERM];  // Expected value
  logic [VAL_W-1:0] t_mask_q [NTERM];  // Care bits
  logic             t_neg_q  [NTERM];  // Term negated
  logic [PAT_W-1:0] t_pat_q  [NTERM];  // Owning pattern
  logic [CLS_W-1:0] t_cls_q  [NTERM];  // Owning clause

  // ------------------------------------------------------------
  // Frame path state
  // ------------------------------------------------------------
  fpf_state_t       state_q;           // Sequencer
  fpf_state_t       state_d;
  logic [7:0]       buf_mem [BUF_LEN]; // Frame store
  logic [CNT_W-1:0] cnt_q;             // Bytes received
  logic [CNT_W-1:0] len_q;             // Frame length
  logic [CNT_W-1:0] rd_q;              // Replay index
  logic             ovf_q;             // Frame too long
  logic             drop_hold_q;       // Verdict kept
  logic             link_s1_q;         // Sync stage one
  logic             link_s2_q;         // Sync stage two
  logic             rx_take;           // Byte accepted
  logic             frame_end;         // Last byte accepted
  logic             verdict;           // Drop decision
  logic [NTERM-1:0] t_match;           // Raw term results
  logic [NTERM-1:0] t_true;            // After term negation
  logic             f_valid;           // Replay into FIFO
  logic [FIFO_W-1:0] f_data;
  logic             f_ready;
  logic             q_valid;           // FIFO head
  logic [FIFO_W-1:0] q_data;
  logic             q_take;            // Output stage loads

  // ------------------------------------------------------------
  // Term table load
  // ------------------------------------------------------------
  // Reloading mid-frame gives that frame an undefined verdict
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NTERM; i++) begin
        t_en_q[i]   <= 1'b0;
        t_off_q[i]  <= CNT_RST;
        t_nb_q[i]   <= '0;
        t_val_q[i]  <= '0;
        t_mask_q[i] <= '0;
        t_neg_q[i]  <= 1'b0;
        t_pat_q[i]  <= '0;
        t_cls_q[i]  <= '0;
      end
    end else if (cfg_wr) begin
      // Oversized lengths clamp to the widest term
      t_en_q[cfg_term]   <= cfg_en;
      t_off_q[cfg_term]  <= cfg_offset;
      t_nb_q[cfg_term]   <= (cfg_nbytes > NB_W'(MAX_NB)) ?
                            NB_W'(MAX_NB) : cfg_nbytes;
      t_val_q[cfg_term]  <= cfg_value;
      t_mask_q[cfg_term] <= cfg_mask;
      t_neg_q[cfg_term]  <= cfg_neg;
      t_pat_q[cfg_term]  <= cfg_pat;
      t_cls_q[cfg_term]  <= cfg_cls;
    end
  end

  // ------------------------------------------------------------
  // Link state synchroniser
  // ------------------------------------------------------------
  // Level comes from the link side, not this clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link_s1_q <= 1'b0;
      link_s2_q <= 1'b0;
    end else begin
      link_s1_q <= link_down;
      link_s2_q <= link_s1_q;
    end
  end

  // ------------------------------------------------------------
  // Receive side
  // ------------------------------------------------------------
  assign rx_take   = rx_valid && rx_ready_q;
  assign frame_end = rx_take && rx_last;

  // Frame store write; bytes past the end are not kept
  always_ff @(posedge clk) begin
    if (rx_take && (cnt_q < CNT_W'(BUF_LEN))) begin
      buf_mem[ADDR_W'(cnt_q)] <= rx_data;
    end
  end

  // Byte counter from frame start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= CNT_RST;
      ovf_q <= 1'b0;
      len_q <= CNT_RST;
    end else if (frame_end) begin
      // Saturating count keeps length sane
      cnt_q <= CNT_RST;
      ovf_q <= ovf_q || (cnt_q == CNT_W'(BUF_LEN));
      len_q <= cnt_q + 1'b1;
    end else if (rx_take) begin
      if (cnt_q == CNT_W'(BUF_LEN)) begin
        ovf_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end else if (state_q == FPF_S_EVAL) begin
      // Verdict has consumed the flag
      ovf_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Term comparators, one per table entry
  // ------------------------------------------------------------
  // Offsets count from the first destination byte
  for (genvar g = 0; g < NTERM; g++) begin : g_term
    fpf_term u_term (
      .clk        (clk),
      .rst_n      (rst_n),
      .byte_valid (rx_take),
      .first      (cnt_q == CNT_RST),
      .byte_cnt   (cnt_q),
      .byte_data  (rx_data),
      .offset     (t_off_q[g]),
      .nbytes     (t_nb_q[g]),
      .value      (t_val_q[g]),
      .mask       (t_mask_q[g]),
      .match      (t_match[g])
    );
    // Per-term negation, usable inside a conjunction
    assign t_true[g] = t_match[g] ^ t_neg_q[g];
  end

  // ------------------------------------------------------------
  // Expression evaluation
  // ------------------------------------------------------------
  // Pattern = [not] AND of clauses, clause = OR of terms.
  // Flat two-level form trades free nesting for one cycle.
  always_comb begin
    logic any_t;
    logic cls_has;
    logic cls_or;
    logic pat_and;
    logic pat_res;
    any_t   = 1'b0;
    cls_has = 1'b0;
    cls_or  = 1'b0;
    pat_and = 1'b1;
    pat_res = 1'b0;
    verdict = 1'b0;
    for (int p = 0; p < NPAT; p++) begin
      any_t   = 1'b0;
      pat_and = 1'b1;
      for (int c = 0; c < NCLS; c++) begin
        cls_has = 1'b0;
        cls_or  = 1'b0;
        for (int t = 0; t < NTERM; t++) begin
          if (t_en_q[t] && (t_pat_q[t] == PAT_W'(p))
              && (t_cls_q[t] == CLS_W'(c))) begin
            cls_has = 1'b1;
            cls_or  = cls_or || t_true[t];
          end
        end
        // Empty clause is neutral
        if (cls_has) begin
          pat_and = pat_and && cls_or;
          any_t   = 1'b1;
        end
      end
      // Group negation covers the whole product
      pat_res = pat_and ^ pat_neg[p];
      // Connect qualifier gates by remote link state
      if (pat_conn[p] && !link_s2_q) begin
        pat_res = 1'b0;
      end
      // Only assigned, populated patterns vote
      if (pat_en[p] && any_t && pat_res) begin
        verdict = 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      FPF_S_RX: begin
        if (frame_end) begin
          state_d = FPF_S_EVAL;
        end
      end
      FPF_S_EVAL: begin
        // Dropped frames skip replay entirely
        if (verdict || ovf_q) begin
          state_d = FPF_S_RX;
        end else begin
          state_d = FPF_S_TX;
        end
      end
      FPF_S_TX: begin
        if (f_valid && f_ready && (rd_q == len_q - 1'b1)) begin
          state_d = FPF_S_RX;
        end
      end
      default: begin
        state_d = FPF_S_RX;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= FPF_S_RX;
    end else begin
      state_q <= state_d;
    end
  end

  // Ready to the LAN side only while collecting
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_ready_q <= 1'b0;
    end else begin
      rx_ready_q <= (state_d == FPF_S_RX);
    end
  end

  // Verdict pulses and held decision
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drop_q      <= 1'b0;
      pass_q      <= 1'b0;
      drop_hold_q <= 1'b0;
    end else begin
      drop_q <= (state_q == FPF_S_EVAL) && (verdict || ovf_q);
      pass_q <= (state_q == FPF_S_EVAL) && !(verdict || ovf_q);
      if (state_q == FPF_S_EVAL) begin
        drop_hold_q <= verdict || ovf_q;
      end
    end
  end

  // ------------------------------------------------------------
  // Replay of a kept frame
  // ------------------------------------------------------------
  // Kept frames leave byte for byte, unchanged
  assign f_valid = (state_q == FPF_S_TX) && !drop_hold_q;
  assign f_data  = {(rd_q == len_q - 1'b1),
                    buf_mem[ADDR_W'(rd_q)]};

  // Replay index, stalls on a full FIFO
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= CNT_RST;
    end else if (state_q != FPF_S_TX) begin
      rd_q <= CNT_RST;
    end else if (f_valid && f_ready) begin
      rd_q <= rd_q + 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Output buffer
  // ------------------------------------------------------------
  // Absorbs bridge stalls so replay runs in bursts
  fpf_fifo #(
    .W     (FIFO_W),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (f_valid),
    .in_data   (f_data),
    .in_ready  (f_ready),
    .out_valid (q_valid),
    .out_data  (q_data),
    .out_ready (q_take)
  );

  // Load output stage when empty or being drained
  assign q_take = q_valid && (!fwd_valid_q || fwd_ready);

  // Registered forward stream
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fwd_valid_q <= 1'b0;
      fwd_data_q  <= BYTE_RST;
      fwd_last_q  <= 1'b0;
    end else if (q_take) begin
      fwd_valid_q <= 1'b1;
      fwd_data_q  <= q_data[7:0];
      fwd_last_q  <= q_data[8];
    end else if (fwd_ready) begin
      fwd_valid_q <= 1'b0;
    end
  end

  // Worked settings, all pure data in the table:
  // type 0800 : offset 12, 2 bytes, mask FFFF
  // TCP byte : offset 23, 1 byte, value 06
  //   600X      : mask FFF0 on the type field
  // multicast : offset 0, 1 byte, mask 80
  // broadcast : offset 0, all-ones value
  // any pattern may set its own pat_neg bit

endmodule

// ==== sim/fpf_filter_assertions.sv ====
`timescale 1ns/1ns
// ------------------------------------------------------------
// Port checker for the frame filter
// ------------------------------------------------------------
module fpf_filter_assertions (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // Receive side
  input wire logic       rx_valid,
  input wire logic       rx_last,
  input wire logic       rx_ready_q,
  // Forward side
  input wire logic       fwd_valid_q,
  input wire logic [7:0] fwd_data_q,
  input wire logic       fwd_last_q,
  input wire logic       fwd_ready,
  // Verdict pulses
  input wire logic       drop_q,
  input wire logic       pass_q
);
  // One clock domain, so clocking and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Final byte of a frame handed over
  sequence last_taken_s;
    rx_valid && rx_ready_q && rx_last;
  endsequence

  // Either verdict pulse
  sequence verdict_s;
    drop_q || pass_q;
  endsequence

  verdict_once_a: assert property (!(drop_q && pass_q))
    else $error("drop and pass together");
  verdict_due_a: assert property (last_taken_s |-> ##2 verdict_s)
    else $error("no verdict two cycles after last byte");
  verdict_cause_a: assert property (
    verdict_s |-> $past(rx_valid && rx_ready_q && rx_last, 2))
    else $error("verdict without a finished frame");
  drop_pulse_a: assert property (drop_q |=> !drop_q)
    else $error("drop pulse longer than one cycle");
  pass_pulse_a: assert property (pass_q |=> !pass_q)
    else $error("pass pulse longer than one cycle");
  rx_closed_a: assert property (last_taken_s |=> !rx_ready_q)
    else $error("receive still open after last byte");
  drop_free_a: assert property (drop_q |-> rx_ready_q)
    else $error("receive not reopened on drop");
  replay_due_a: assert property (pass_q |-> ##[1:8] fwd_valid_q)
    else $error("kept frame not forwarded");
  fwd_hold_a: assert property (fwd_valid_q && !fwd_ready |=>
    fwd_valid_q && $stable(fwd_data_q) && $stable(fwd_last_q))
    else $error("forward byte changed while stalled");
endmodule

bind fpf_filter fpf_filter_assertions i_chk (
  .clk         (clk),
  .rst_n       (rst_n),
  .rx_valid    (rx_valid),
  .rx_last     (rx_last),
  .rx_ready_q  (rx_ready_q),
  .fwd_valid_q (fwd_valid_q),
  .fwd_data_q  (fwd_data_q),
  .fwd_last_q  (fwd_last_q),
  .fwd_ready   (fwd_ready),
  .drop_q      (drop_q),
  .pass_q      (pass_q)
);

// ==== sim/fpf_sink.sv ====
`timescale 1ns/1ns
// ------------------------------------------------------------
// Bridge side model: takes forwarded bytes
// ------------------------------------------------------------
module fpf_sink (
  // Clock
  input wire logic       clk,
  // Forward stream from the filter
  input wire logic       fwd_valid_q,
  input wire logic [7:0] fwd_data_q,
  input wire logic       fwd_last_q,
  output logic           fwd_ready,
  // Bench control: hold off the stream
  input wire logic       stall
);
  logic [8:0] got [$];  // Last flag and byte, in arrival order

  // Slow bridge just withdraws ready; no partial acceptance
  assign fwd_ready = !stall;

  // Record a byte only on a real handshake
  always @(posedge clk) begin
    if (fwd_valid_q && fwd_ready) begin
      got.push_back({fwd_last_q, fwd_data_q});
    end
  end
endmodule

// ==== sim/tb.sv ====
`timescale 1ns/1ns
// ------------------------------------------------------------
// Frame filter bench
// ------------------------------------------------------------
module tb;
  import fpf_pkg::*;
  logic              clk, rst_n, stall, link_down;
  logic              rx_valid, rx_last, rx_ready_q;
  logic [7:0]        rx_data, fwd_data_q;
  logic              fwd_valid_q, fwd_last_q, fwd_ready;
  logic              cfg_wr, cfg_en, cfg_neg, drop_q, pass_q;
  logic [TIDX_W-1:0] cfg_term;
  logic [CNT_W-1:0]  cfg_offset;
  logic [NB_W-1:0]   cfg_nbytes;
  logic [VAL_W-1:0]  cfg_value, cfg_mask;
  logic [PAT_W-1:0]  cfg_pat;
  logic [CLS_W-1:0]  cfg_cls;
  logic [NPAT-1:0]   pat_en, pat_neg, pat_conn;
  logic [7:0]        fr [64];   // Frame under test
  int                miscompares, checked;

  fpf_filter i_dut (.clk(clk), .rst_n(rst_n), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_last(rx_last), .rx_ready_q(rx_ready_q),
    .fwd_valid_q(fwd_valid_q), .fwd_data_q(fwd_data_q),
    .fwd_last_q(fwd_last_q), .fwd_ready(fwd_ready), .cfg_wr(cfg_wr),
    .cfg_term(cfg_term), .cfg_en(cfg_en), .cfg_offset(cfg_offset),
    .cfg_nbytes(cfg_nbytes), .cfg_value(cfg_value), .cfg_mask(cfg_mask),
    .cfg_neg(cfg_neg), .cfg_pat(cfg_pat), .cfg_cls(cfg_cls),
    .pat_en(pat_en), .pat_neg(pat_neg), .pat_conn(pat_conn),
    .link_down(link_down), .drop_q(drop_q), .pass_q(pass_q));
  fpf_sink i_sink (.clk(clk), .fwd_valid_q(fwd_valid_q),
    .fwd_data_q(fwd_data_q), .fwd_last_q(fwd_last_q),
    .fwd_ready(fwd_ready), .stall(stall));

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task test_done;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Step to the drive point just after a rising edge
  task tick;
    @(posedge clk);
    #5;
  endtask

  // Reset also clears the term table, so every test starts clean
  task reset(input int n);
    rst_n = 1'b0;
    {pat_en, pat_neg, pat_conn} = '0;
    repeat (n) tick;
    rst_n = 1'b1;
    tick;
  endtask

  // Load one term; the pattern vote is opened by pat_en later
  task term(input logic [2:0] t, input logic [11:0] off,
            input logic [2:0] nb, input logic [31:0] v, m,
            input logic ng, input logic [1:0] p, c);
    {cfg_wr, cfg_en, cfg_term, cfg_offset, cfg_nbytes} = {2'b11, t, off, nb};
    {cfg_value, cfg_mask, cfg_neg, cfg_pat, cfg_cls} = {v, m, ng, p, c};
    tick;
    cfg_wr = 1'b0;
    tick;
  endtask

  // Plain frame with chosen destination top byte, type and proto byte
  task mk(input logic [7:0] b0, input logic [15:0] ty,
          input logic [7:0] b23);
    for (int i = 0; i < 64; i++) fr[i] = 8'h30 + 8'(i);
    {fr[0], fr[12], fr[13], fr[23]} = {b0, ty, b23};
  endtask

  // Send n bytes, judge the verdict, and for a kept frame its replay
  task frame(input int n, input logic exp_drop);
    int k;
    i_sink.got.delete();
    for (int i = 0; i < n; i++) begin
      {rx_valid, rx_data, rx_last} = {1'b1, fr[i], i == n - 1};
      for (k = 0; rx_ready_q !== 1'b1 && k < 400; k++) tick;
      if (k >= 400) begin miscompares++; test_done; end
      tick;
    end
    {rx_valid, rx_last} = 2'b00;
    for (k = 0; drop_q !== 1'b1 && pass_q !== 1'b1 && k < 9; k++) tick;
    if (k >= 9) begin miscompares++; test_done; end
    chk({drop_q, pass_q}, {exp_drop, !exp_drop});
    if (!exp_drop) begin
      for (k = 0; i_sink.got.size() < n && k < 2000; k++) tick;
      if (k >= 2000) begin miscompares++; test_done; end
      chk(i_sink.got.size(), n);
      for (int i = 0; i < n && i < i_sink.got.size(); i++)
        chk(i_sink.got[i], {i == n - 1, fr[i]});
    end
  endtask

  task t_ip;
    reset(2);
    term(0, 12, 2, 'h0800, 'hFFFF, 0, 0, 0);
    pat_en = 4'h1;
    mk(8'h10, 16'h0800, 8'h06); frame(32, 1'b1);
    frame(14, 1'b1);
    frame(13, 1'b0);
    mk(8'h10, 16'h0806, 8'h06); frame(32, 1'b0);
    mk(8'h10, 16'h0008, 8'h06); frame(32, 1'b0);
    $display("t_ip done");
  endtask

  // Single negated pattern: only IP passes
  task t_not;
    reset(2);
    term(0, 12, 2, 'h0800, 'hFFFF, 0, 0, 0);
    {pat_en, pat_neg} = 8'h11;
    mk(8'h10, 16'h0800, 8'h06); frame(32, 1'b0);
    mk(8'h10, 16'h6004, 8'h06); frame(32, 1'b1);
    $display("t_not done");
  endtask

  task t_and;
    reset(2);
    term(0, 12, 2, 'h0800, 'hFFFF, 0, 0, 0);
    term(1, 23, 1, 'h06, 'hFF, 0, 0, 1);
    pat_en = 4'h1;
    mk(8'h10, 16'h0800, 8'h06); frame(32, 1'b1);
    mk(8'h10, 16'h0800, 8'h11); frame(32, 1'b0);
    mk(8'h10, 16'h0806, 8'h06); frame(32, 1'b0);
    term(1, 23, 1, 'h06, 'hFF, 1, 0, 1);
    mk(8'h10, 16'h0800, 8'h11); frame(32, 1'b1);
    mk(8'h10, 16'h0800, 8'h06); frame(32, 1'b0);
    $display("t_and done");
  endtask

  // Low nibble of the type is a don't-care
  task t_nib;
    reset(2);
    term(0, 12, 2, 'h6000, 'hFFF0, 0, 0, 0);
    pat_en = 4'h1;
    for (int j = 0; j < 16; j += 15) begin
      mk(8'h10, 16'h6000 + 16'(j), 8'h06); frame(24, 1'b1);
    end
    mk(8'h10, 16'h6010, 8'h06); frame(24, 1'b0);
    $display("t_nib done");
  endtask

  // Top destination bit only; broadcast caught as well
  task t_mc;
    reset(2);
    term(0, 0, 1, 'h80, 'h80, 0, 0, 0);
    pat_en = 4'h1;
    mk(8'h81, 16'h0800, 8'h06); frame(24, 1'b1);
    mk(8'hFF, 16'h0800, 8'h06); frame(24, 1'b1);
    mk(8'h7F, 16'h0800, 8'h06); frame(24, 1'b0);
    $display("t_mc done");
  endtask

  // Six destination bytes as two overlapping four byte terms
  task t_bc;
    reset(2);
    term(0, 0, 4, 'hFFFFFFFF, 'hFFFFFFFF, 0, 0, 0);
    term(1, 2, 4, 'hFFFFFFFF, 'hFFFFFFFF, 0, 0, 1);
    pat_en = 4'h1;
    mk(8'hFF, 16'h0806, 8'h06);
    for (int i = 1; i < 6; i++) fr[i] = 8'hFF;
    frame(24, 1'b1);
    fr[5] = 8'hFE;
    frame(24, 1'b0);
    $display("t_bc done");
  endtask

  // Two terms in one clause, then the link qualifier
  task t_or;
    reset(2);
    term(0, 10, 1, 'h20, 'hFF, 0, 1, 0);
    term(1, 12, 1, 'h80, 'hFF, 0, 1, 0);
    pat_en = 4'h2;
    mk(8'h10, 16'h8000, 8'h06); frame(24, 1'b1);
    mk(8'h10, 16'h0800, 8'h06); frame(24, 1'b0);
    fr[10] = 8'h20; frame(24, 1'b1);
    pat_conn = 4'h2;
    frame(24, 1'b0);
    link_down = 1'b1;
    repeat (3) tick;
    frame(24, 1'b1);
    link_down = 1'b0;
    $display("t_or done");
  endtask

  // Stalled bridge: FIFO fills, receive stays shut until the last byte is replayed into the FIFO
  task t_stall;
    reset(2);
    stall = 1'b1;
    fork
      begin
        repeat (140) @(posedge clk);
        #5;
        chk(rx_ready_q, 0);
        chk(i_sink.got.size(), 0);
        stall = 1'b0;
      end
    join_none
    mk(8'h10, 16'h0800, 8'h06); frame(40, 1'b0);
    $display("t_stall done");
  endtask

  initial begin
    {rst_n, rx_valid, rx_data, rx_last, stall, link_down} = '0;
    {cfg_wr, cfg_term, cfg_en, cfg_offset, cfg_nbytes} = '0;
    {cfg_value, cfg_mask, cfg_neg, cfg_pat, cfg_cls} = '0;
    {pat_en, pat_neg, pat_conn} = '0;
    miscompares = 0;
    checked = 0;
    reset(20);
    t_ip;
    t_not;
    t_and;
    t_nib;
    t_mc;
    t_bc;
    t_or;
    t_stall;
    test_done;
  end
endmodule
